// File: rtl/ddrci_top.sv
// Memory-side command decode, bank tracking, posted latency and bursts
`timescale 1ns/1ps

// How it works
// - Commands and addresses are taken only where true clock rises, complement falls.
// - Burst beats are timed on both clock crossings, two per clock period.
// - Clock gate sampled low suspends internal ticks from the next crossing on.
// - Gate low with all banks idle enters power-down or self-refresh.
// - Bank-select inputs pick which of four banks a command acts on.
// - Activate captures all thirteen address bits as the bank's open row.
// - Column taken from ten low address bits; bit ten requests auto-precharge.
// - Auto-precharge closes the accessed bank after the burst's last beat.
// - Bursts of four or eight beats in sequential or interleaved order.
// - Column commands are posted by an additive latency of zero to six.
// - Write data is expected one clock earlier than read data when the CAS latency is two or more.
// - Commands are ignored while chip-select is sampled high.
// - Row strobe low, column high: write-enable picks activate or precharge.
// - Column strobe low, row high: write-enable picks read or write.
// - Write bytes whose mask is high are discarded per lane.
module ddrci_top #(
	parameter int FIFO_DEPTH = ddrci_pkg::FIFO_DEPTH_DEF
) (
	input  wire logic                              clock,
	input  wire logic                              reset_n,
	input  wire logic                              clk_en,
	input  wire logic                              ck_pin,
	input  wire logic                              clock_complement,
	input  wire logic                              cke_pin,
	input  wire logic                              cs_n_pin,
	input  wire logic                              ras_n_pin,
	input  wire logic                              cas_n_pin,
	input  wire logic                              we_n_pin,
	input  wire logic [ddrci_pkg::BANK_W-1:0]      bank_select_inputs,
	input  wire logic [ddrci_pkg::ROW_W-1:0]       multiplexed_address_inputs,
	input  wire logic [ddrci_pkg::DQ_W-1:0]        dq_pin,
	input  wire logic                              low_byte_mask,
	input  wire logic                              high_byte_mask,
	input  wire logic                              burst_len_8,
	input  wire logic                              burst_interleave,
	input  wire logic [ddrci_pkg::LAT_W-1:0]       cas_latency,
	input  wire logic [ddrci_pkg::LAT_W-1:0]       additive_latency,
	input  wire logic                              wr_out_ready,
	output ddrci_pkg::ddrci_req_t                  cmd_r,
	output logic                                   cmd_valid_r,
	output logic [ddrci_pkg::NBANK-1:0]            banks_open_r,
	output ddrci_pkg::ddrci_beat_t                 beat_r,
	output logic                                   beat_valid_r,
	output logic                                   auto_pre_r,
	output logic                                   low_power_r,
	output logic                                   self_refresh_r,
	output logic                                   wr_drop_r,
	output logic                                   wr_out_valid,
	output ddrci_pkg::ddrci_wdat_t                 wr_out_data
);

	localparam int NB = ddrci_pkg::NBANK;
	localparam int AM = ddrci_pkg::AL_MAX;
	localparam int LW = ddrci_pkg::LAT_W;
	localparam int IW = ddrci_pkg::IDX_W;
	localparam int CW = ddrci_pkg::COL_W;

	if (FIFO_DEPTH < 2) begin : g_chk
		$error("ddrci_top: FIFO_DEPTH must be at least 2");
	end

	ddrci_pkg::ddrci_pins_t pin_w;
	ddrci_pkg::ddrci_pins_t sync1_r;
	ddrci_pkg::ddrci_pins_t p;
	logic                   ck_prev_r;
	logic                   cke_q_r;

	assign pin_w = '{ck: ck_pin, ck_c: clock_complement, cke: cke_pin,
		cs_n: cs_n_pin, ras_n: ras_n_pin, cas_n: cas_n_pin, we_n: we_n_pin,
		ba: bank_select_inputs, addr: multiplexed_address_inputs,
		dq: dq_pin, dm: {high_byte_mask, low_byte_mask}};

	// Pins are asynchronous to clock; only the second stage is read
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sync1_r <= '0;
			p       <= '0;
		end else if (clk_en) begin
			sync1_r <= pin_w;
			p       <= sync1_r;
		end
	end

	// Crossing detection on the synchronised pair
	wire rise_x = p.ck & ~p.ck_c & ~ck_prev_r;
	wire fall_x = ~p.ck & p.ck_c & ck_prev_r;
	wire tick_r = rise_x & cke_q_r;
	wire tick_f = fall_x & cke_q_r;
	wire edge_x = tick_r | tick_f;

	// Command decode
	wire cmd_ok = tick_r & ~p.cs_n;
	wire act_c  = cmd_ok & ~p.ras_n & p.cas_n & p.we_n;
	wire pre_c  = cmd_ok & ~p.ras_n & p.cas_n & ~p.we_n;
	wire rd_c   = cmd_ok & p.ras_n & ~p.cas_n & p.we_n;
	wire wr_c   = cmd_ok & p.ras_n & ~p.cas_n & ~p.we_n;
	wire ref_c  = cmd_ok & ~p.ras_n & ~p.cas_n & p.we_n;
	wire mrs_c  = cmd_ok & ~p.ras_n & ~p.cas_n & ~p.we_n;
	wire col_c  = rd_c | wr_c;

	ddrci_pkg::ddrci_cmd_t kind_w;
	assign kind_w = act_c ? ddrci_pkg::DDRCI_ACT :
		pre_c ? ddrci_pkg::DDRCI_PRE :
		rd_c  ? ddrci_pkg::DDRCI_RD  :
		wr_c  ? ddrci_pkg::DDRCI_WR  :
		ref_c ? ddrci_pkg::DDRCI_REF :
		mrs_c ? ddrci_pkg::DDRCI_MRS : ddrci_pkg::DDRCI_NOP;

	ddrci_pkg::ddrci_col_t new_col;
	assign new_col = '{v: col_c, bank: p.ba,
		col: p.addr[CW-1:0], wr: wr_c,
		ap: p.addr[ddrci_pkg::AP_BIT]};

	// Posted column commands wait in a shift line indexed by latency
	ddrci_pkg::ddrci_col_t post_r [AM];
	ddrci_pkg::ddrci_col_t post_nxt [AM];
	ddrci_pkg::ddrci_col_t iss;

	for (genvar i = 0; i < AM; i++) begin : g_post
		ddrci_pkg::ddrci_col_t down;
		if (i == AM - 1) begin : g_end
			assign down = '0;
		end else begin : g_mid
			assign down = post_r[i+1];
		end
		assign post_nxt[i] = !tick_r ? post_r[i] :
			(col_c && additive_latency == LW'(i + 1)) ? new_col :
			down;
	end

	assign iss = !tick_r ? '0 :
		(col_c && additive_latency == '0) ? new_col : post_r[0];

	// Access engine
	ddrci_pkg::ddrci_st_t   st_r;
	ddrci_pkg::ddrci_st_t   st_nxt;
	ddrci_pkg::ddrci_col_t  acc_r;
	logic [LW-1:0]          cnt_r;
	logic [IW-1:0]          idx_r;
	logic [ddrci_pkg::ROW_W-1:0] rows_w [NB];

	wire [LW-1:0] lat_raw = iss.wr ? cas_latency - LW'(1) : cas_latency;
	wire [LW-1:0] lat_w   = (lat_raw == '0) ? LW'(1) : lat_raw;
	wire          beat_now = edge_x &&
		((st_r == ddrci_pkg::DDRCI_WAIT && cnt_r == LW'(1) && tick_r) ||
		st_r == ddrci_pkg::DDRCI_BURST);
	wire [IW-1:0] last_idx = burst_len_8 ? ddrci_pkg::LAST_BL8 :
		ddrci_pkg::LAST_BL4;
	wire [IW-1:0] ord_mask = burst_len_8 ? ddrci_pkg::MASK_BL8 :
		ddrci_pkg::MASK_BL4;
	wire [IW-1:0] start_lo = acc_r.col[IW-1:0];
	wire [IW-1:0] ord_lo   = burst_interleave ? (start_lo ^ idx_r) :
		(start_lo + idx_r);
	wire [CW-1:0] beat_col = (acc_r.col & ~CW'(ord_mask)) |
		CW'(ord_lo & ord_mask);
	wire          burst_end = beat_now && idx_r == last_idx;
	wire          ap_fire   = burst_end & acc_r.ap;

	always_comb begin
		st_nxt = st_r;
		if (iss.v) begin
			st_nxt = ddrci_pkg::DDRCI_WAIT;
		end else if (burst_end) begin
			st_nxt = ddrci_pkg::DDRCI_IDLE;
		end else if (beat_now) begin
			st_nxt = ddrci_pkg::DDRCI_BURST;
		end
	end

	// Bank state: one open flag and row per bank
	logic [NB-1:0] open_nxt;
	logic [ddrci_pkg::ROW_W-1:0] row_r [NB];
	logic [ddrci_pkg::ROW_W-1:0] row_nxt [NB];

	for (genvar b = 0; b < NB; b++) begin : g_bank
		wire hit   = p.ba == ddrci_pkg::BANK_W'(b);
		wire close = (pre_c & (hit | p.addr[ddrci_pkg::AP_BIT])) |
			(ap_fire && acc_r.bank == ddrci_pkg::BANK_W'(b));
		assign open_nxt[b] = (act_c & hit) | (banks_open_r[b] & ~close);
		assign row_nxt[b]  = (act_c & hit) ? p.addr : row_r[b];
		assign rows_w[b]   = row_r[b];
	end

	wire all_idle = banks_open_r == '0;
	wire cke_drop = tick_r & ~p.cke;

	// Write path; a full buffer drops the beat since the link cannot wait
	ddrci_pkg::ddrci_wdat_t wd_in;
	wire wd_valid = beat_now & acc_r.wr;
	wire wd_ready;
	wire [ddrci_pkg::DM_W-1:0] ben = ~p.dm;

	assign wd_in = '{bank: acc_r.bank, row: rows_w[acc_r.bank],
		col: beat_col, byte_en: ben,
		data: p.dq & {{8{ben[1]}}, {8{ben[0]}}}};

	ddrci_fifo #(
		.WIDTH ($bits(ddrci_pkg::ddrci_wdat_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wbuf (
		.clock     (clock),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.in_valid  (wd_valid),
		.in_ready  (wd_ready),
		.in_data   (wd_in),
		.out_valid (wr_out_valid),
		.out_ready (wr_out_ready),
		.out_data  (wr_out_data)
	);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ck_prev_r <= 1'b0;
			cke_q_r   <= 1'b0;
			post_r    <= '{default: '0};
			row_r     <= '{default: '0};
			banks_open_r <= '0;
		end else if (clk_en) begin
			ck_prev_r <= p.ck;
			if (rise_x) begin
				cke_q_r <= p.cke;
			end
			post_r       <= post_nxt;
			row_r        <= row_nxt;
			banks_open_r <= open_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_r  <= ddrci_pkg::DDRCI_IDLE;
			acc_r <= '0;
			cnt_r <= '0;
			idx_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			if (iss.v) begin
				acc_r <= iss;
				cnt_r <= lat_w;
				idx_r <= '0;
			end else begin
				if (tick_r && st_r == ddrci_pkg::DDRCI_WAIT) begin
					cnt_r <= cnt_r - LW'(1);
				end
				if (beat_now) begin
					idx_r <= idx_r + IW'(1);
				end
			end
		end
	end

	// Status and event outputs
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cmd_r          <= '0;
			cmd_valid_r    <= 1'b0;
			beat_r         <= '0;
			beat_valid_r   <= 1'b0;
			auto_pre_r     <= 1'b0;
			low_power_r    <= 1'b0;
			self_refresh_r <= 1'b0;
			wr_drop_r      <= 1'b0;
		end else if (clk_en) begin
			cmd_valid_r  <= cmd_ok;
			if (cmd_ok) begin
				cmd_r <= '{kind: kind_w, bank: p.ba, addr: p.addr};
			end
			beat_valid_r <= beat_now;
			beat_r       <= '{bank: acc_r.bank, row: rows_w[acc_r.bank],
				col: beat_col, wr: acc_r.wr, rise: tick_r};
			auto_pre_r   <= ap_fire;
			if (wd_valid & ~wd_ready) begin
				wr_drop_r <= 1'b1;
			end
			if (rise_x & p.cke) begin
				low_power_r    <= 1'b0;
				self_refresh_r <= 1'b0;
			end else if (cke_drop & all_idle & ref_c) begin
				self_refresh_r <= 1'b1;
			end else if (cke_drop & all_idle & ~ref_c) begin
				low_power_r <= 1'b1;
			end
		end
	end

endmodule : ddrci_top

// File: rtl/ddrci_pkg.sv
// Shared widths, command encodings and carrier structs for the command port
package ddrci_pkg;

	localparam int BANK_W = 2;
	localparam int NBANK  = 4;
	localparam int ROW_W  = 13;
	localparam int COL_W  = 10;
	localparam int DQ_W   = 16;
	localparam int DM_W   = 2;
	localparam int AP_BIT = 10;
	localparam int AL_MAX = 6;
	localparam int IDX_W  = 3;
	localparam int LAT_W  = 3;
	localparam logic [IDX_W-1:0] LAST_BL4 = 3'h3;
	localparam logic [IDX_W-1:0] LAST_BL8 = 3'h7;
	localparam logic [IDX_W-1:0] MASK_BL4 = 3'h3;
	localparam logic [IDX_W-1:0] MASK_BL8 = 3'h7;
	localparam int FIFO_DEPTH_DEF = 8;

	typedef enum logic [2:0] {
		DDRCI_NOP, DDRCI_ACT, DDRCI_PRE, DDRCI_RD, DDRCI_WR, DDRCI_REF,
		DDRCI_MRS
	} ddrci_cmd_t;

	typedef enum logic [1:0] {DDRCI_IDLE, DDRCI_WAIT, DDRCI_BURST} ddrci_st_t;

	typedef struct packed {
		logic              ck;
		logic              ck_c;
		logic              cke;
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic [BANK_W-1:0] ba;
		logic [ROW_W-1:0]  addr;
		logic [DQ_W-1:0]   dq;
		logic [DM_W-1:0]   dm;
	} ddrci_pins_t;

	typedef struct packed {
		ddrci_cmd_t        kind;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0]  addr;
	} ddrci_req_t;

	typedef struct packed {
		logic              v;
		logic [BANK_W-1:0] bank;
		logic [COL_W-1:0]  col;
		logic              wr;
		logic              ap;
	} ddrci_col_t;

	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
		logic              wr;
		logic              rise;
	} ddrci_beat_t;

	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
		logic [DQ_W-1:0]   data;
		logic [DM_W-1:0]   byte_en;
	} ddrci_wdat_t;

endpackage : ddrci_pkg

// File: rtl/ddrci_fifo.sv
// Shift-register FIFO with registered outputs and ready on both sides
`timescale 1ns/1ps
module ddrci_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_chk
		$error("ddrci_fifo: DEPTH must be at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic [CW-1:0]    wr_at;
	logic [DEPTH-1:0] vld_r;
	logic [DEPTH-1:0] vld_nxt;
	wire              push = in_valid & ~vld_r[DEPTH-1];
	wire              pop  = vld_r[0] & out_ready;

	// Entries shift toward slot 0 so the head is always a flop
	assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
	assign wr_at   = pop ? cnt_r - CW'(1) : cnt_r;

	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		wire [WIDTH-1:0] shifted;
		if (i == DEPTH - 1) begin : g_last
			assign shifted = mem_r[i];
		end else begin : g_mid
			assign shifted = pop ? mem_r[i+1] : mem_r[i];
		end
		assign mem_nxt[i] = (push && wr_at == CW'(i)) ? in_data : shifted;
		assign vld_nxt[i] = cnt_nxt > CW'(i);
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cnt_r <= '0;
			vld_r <= '0;
		end else if (clk_en) begin
			cnt_r <= cnt_nxt;
			vld_r <= vld_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (clk_en) begin
			mem_r <= mem_nxt;
		end
	end

	assign in_ready  = ~vld_r[DEPTH-1];
	assign out_valid = vld_r[0];
	assign out_data  = mem_r[0];

endmodule : ddrci_fifo

// File: dv/ddrci_top_monitor.sv
// Concurrent checks on the command port outputs
`timescale 1ns/1ps
module ddrci_top_monitor (
	input wire logic                          clock,
	input wire logic                          reset_n,
	input wire logic                          wr_out_ready,
	input wire ddrci_pkg::ddrci_req_t         cmd_r,
	input wire logic                          cmd_valid_r,
	input wire logic [ddrci_pkg::NBANK-1:0]   banks_open_r,
	input wire ddrci_pkg::ddrci_beat_t        beat_r,
	input wire logic                          beat_valid_r,
	input wire logic                          auto_pre_r,
	input wire logic                          low_power_r,
	input wire logic                          self_refresh_r,
	input wire logic                          wr_out_valid,
	input wire ddrci_pkg::ddrci_wdat_t        wr_out_data
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_rise;
		beat_valid_r && beat_r.rise;
	endsequence
	sequence s_fall;
		beat_valid_r && !beat_r.rise;
	endsequence
	wire act_w = cmd_valid_r && cmd_r.kind == ddrci_pkg::DDRCI_ACT;
	wire pre_w = cmd_valid_r && cmd_r.kind == ddrci_pkg::DDRCI_PRE;
	AST_ACT_OPENS: assert property (act_w |-> banks_open_r[cmd_r.bank])
		else $error("activate left its bank closed");
	AST_PRE_CLOSES: assert property (pre_w |-> !banks_open_r[cmd_r.bank])
		else $error("precharge left its bank open");
	AST_PRE_ALL: assert property (pre_w && cmd_r.addr[10] |-> !(|banks_open_r))
		else $error("precharge all left a bank open");
	AST_CMD_GAP: assert property (cmd_valid_r |=> !cmd_valid_r [*8])
		else $error("two commands inside one link clock");
	AST_BEAT_PAIR: assert property (s_rise |-> ##[1:8] s_fall)
		else $error("rising beat without its falling partner");
	AST_BEAT_GAP: assert property (beat_valid_r |=> !beat_valid_r [*4])
		else $error("beats closer than half a link clock");
	AST_AUTOPRE: assert property (auto_pre_r |->
		s_fall ##1 !banks_open_r[$past(beat_r.bank)])
		else $error("auto precharge not at last beat or bank open");
	AST_LP_IDLE: assert property (low_power_r || self_refresh_r |->
		!(|banks_open_r))
		else $error("low power entered with a bank open");
	AST_MASK: assert property (wr_out_valid |->
		(wr_out_data.byte_en[0] || wr_out_data.data[7:0] == 8'h00) &&
		(wr_out_data.byte_en[1] || wr_out_data.data[15:8] == 8'h00))
		else $error("masked byte lane carries data");
	AST_HEAD_HOLD: assert property (wr_out_valid && !wr_out_ready |=>
		wr_out_valid && $stable(wr_out_data))
		else $error("write queue head changed while stalled");
endmodule : ddrci_top_monitor
bind ddrci_top ddrci_top_monitor u_ddrci_top_monitor (.clock, .reset_n,
	.wr_out_ready, .cmd_r, .cmd_valid_r, .banks_open_r, .beat_r, .beat_valid_r,
	.auto_pre_r, .low_power_r, .self_refresh_r, .wr_out_valid, .wr_out_data);

// File: dv/ddrci_ctrl_model.sv
// Memory controller model driving the link pins
`timescale 1ns/1ps
module ddrci_ctrl_model (
	output logic        ck,
	output logic        ck_c,
	output logic        cke,
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic [1:0]  ba,
	output logic [12:0] a,
	output logic [15:0] dq,
	output logic        dm_lo,
	output logic        dm_hi
);
	// Refresh pacing is left out; runs are far shorter than one interval
	initial begin
		{ck, ck_c, cke} = 3'h2;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		{ba, a, dq, dm_lo, dm_hi} = 33'h0;
	end
	task automatic flip();
		#62.5;
		ck = ~ck;
		ck_c = ~ck_c;
	endtask : flip
	task automatic run(input int n);
		repeat (2 * n) flip();
	endtask : run
	task automatic set_cke(input logic v);
		cke = v;
	endtask : set_cke
	// Pins move a quarter period away from each crossing, so the
	// synchroniser never sees a pin change together with the clock
	task automatic cmd(input logic [3:0] code, input logic [1:0] b,
		input logic [12:0] adr, input int wl, input int nb,
		input logic [15:0] base, input logic [1:0] mask);
		int x;
		for (x = 0; x < 2 * wl + nb + 2; x++) begin
			#31.25;
			if (x == 0) begin
				{cs_n, ras_n, cas_n, we_n} = code;
				ba = b;
				a = adr;
			end else if (x == 1) begin
				// Released lines show inverted junk, not the old value
				{cs_n, ras_n, cas_n, we_n} = 4'hf;
				ba = ~ba;
				a = ~a;
			end
			if (x >= 2 * wl && x < 2 * wl + nb) begin
				dq = 16'(base + x - 2 * wl);
				{dm_hi, dm_lo} = mask;
			end else begin
				dq = ~dq;
			end
			#31.25;
			ck = ~ck;
			ck_c = ~ck_c;
		end
	endtask : cmd
endmodule : ddrci_ctrl_model

// File: dv/tb_top.sv
// Self-checking bench for the memory-side command port
`timescale 1ns/1ps
`define CHK(act, exp) begin \
	compares++; \
	if ((act) !== (exp)) begin \
		n_fail++; \
		$display("BAD %0t got %h want %h", $time, act, exp); \
	end \
end
module tb_top;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic burst_len_8 = 1'b0;
	logic burst_interleave = 1'b0;
	logic wr_out_ready = 1'b0;
	logic [2:0] cas_latency = 3'h3;
	logic [2:0] additive_latency = 3'h0;
	logic ck_pin, clock_complement, cke_pin, cs_n_pin, ras_n_pin;
	logic cas_n_pin, we_n_pin, low_byte_mask, high_byte_mask;
	logic [1:0] bank_select_inputs;
	logic [12:0] multiplexed_address_inputs;
	logic [15:0] dq_pin;
	ddrci_pkg::ddrci_req_t cmd_r;
	ddrci_pkg::ddrci_beat_t beat_r;
	ddrci_pkg::ddrci_wdat_t wr_out_data;
	logic cmd_valid_r, beat_valid_r, auto_pre_r, low_power_r;
	logic self_refresh_r, wr_drop_r, wr_out_valid;
	logic [3:0] banks_open_r;
	int n_fail = 0, compares = 0, n_cmd = 0, n_ap = 0;
	always #5 clock = ~clock;
	// Pulses are counted at the falling edge, away from their launch
	always @(negedge clock) begin
		if (cmd_valid_r === 1'b1) n_cmd++;
		if (auto_pre_r === 1'b1) n_ap++;
	end
	ddrci_top u_ddrci_top (.clock, .reset_n, .clk_en, .ck_pin,
		.clock_complement, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin,
		.we_n_pin, .bank_select_inputs, .multiplexed_address_inputs, .dq_pin,
		.low_byte_mask, .high_byte_mask, .burst_len_8, .burst_interleave,
		.cas_latency, .additive_latency, .wr_out_ready, .cmd_r, .cmd_valid_r,
		.banks_open_r, .beat_r, .beat_valid_r, .auto_pre_r, .low_power_r,
		.self_refresh_r, .wr_drop_r, .wr_out_valid, .wr_out_data);
	ddrci_ctrl_model u_ddrci_ctrl_model (.ck(ck_pin), .ck_c(clock_complement),
		.cke(cke_pin), .cs_n(cs_n_pin), .ras_n(ras_n_pin), .cas_n(cas_n_pin),
		.we_n(we_n_pin), .ba(bank_select_inputs),
		.a(multiplexed_address_inputs), .dq(dq_pin), .dm_lo(low_byte_mask),
		.dm_hi(high_byte_mask));
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic wait_hi(input int k);
		int i;
		for (i = 0; i < 80; i++) begin
			@(negedge clock);
			if ((k == 0 ? cmd_valid_r : k == 1 ? beat_valid_r : wr_out_valid)
				=== 1'b1) return;
		end
		n_fail++;
		$display("BAD %0t wait ran out", $time);
		tally_and_finish();
	endtask : wait_hi
	task automatic t_rows();
		int n;
		u_ddrci_ctrl_model.set_cke(1'b1);
		u_ddrci_ctrl_model.run(2);
		fork
			u_ddrci_ctrl_model.cmd(4'h3, 2'h2, 13'h1abc, 0, 0, 16'h0, 2'h0);
			wait_hi(0);
		join
		`CHK(cmd_r.kind, ddrci_pkg::DDRCI_ACT)
		`CHK(cmd_r.bank, 2'h2)
		`CHK(cmd_r.addr, 13'h1abc)
		`CHK(banks_open_r, 4'h4)
		n = n_cmd;
		u_ddrci_ctrl_model.cmd(4'hb, 2'h1, 13'h0001, 0, 0, 16'h0, 2'h0);
		u_ddrci_ctrl_model.run(1);
		`CHK(n_cmd, n)
		`CHK(banks_open_r, 4'h4)
		fork
			u_ddrci_ctrl_model.cmd(4'h2, 2'h2, 13'h0000, 0, 0, 16'h0, 2'h0);
			wait_hi(0);
		join
		`CHK(banks_open_r, 4'h0)
		$display("rows done");
	endtask : t_rows
	task automatic t_write();
		int i;
		@(negedge clock);
		burst_len_8 = 1'b1;
		additive_latency = 3'h2;
		u_ddrci_ctrl_model.cmd(4'h3, 2'h1, 13'h0123, 0, 0, 16'h0, 2'h0);
		u_ddrci_ctrl_model.cmd(4'h4, 2'h1, 13'h0405, 4, 8, 16'h3c40, 2'h2);
		`CHK(n_ap, 1)
		`CHK(banks_open_r, 4'h0)
		u_ddrci_ctrl_model.cmd(4'h3, 2'h1, 13'h0123, 0, 0, 16'h0, 2'h0);
		u_ddrci_ctrl_model.cmd(4'h4, 2'h1, 13'h0005, 4, 8, 16'h5a00, 2'h0);
		u_ddrci_ctrl_model.run(1);
		`CHK(wr_drop_r, 1'b1)
		for (i = 0; i < 8; i++) begin
			wait_hi(2);
			`CHK(wr_out_data.col, 10'((5 + i) % 8))
			`CHK(wr_out_data.data, 16'(16'h0040 + i))
			`CHK(wr_out_data.byte_en, 2'h1)
			`CHK(wr_out_data.row, 13'h0123)
			wr_out_ready = 1'b1;
			@(negedge clock);
			wr_out_ready = 1'b0;
		end
		@(negedge clock);
		`CHK(wr_out_valid, 1'b0)
		$display("write done");
	endtask : t_write
	task automatic t_read();
		int i;
		longint t0;
		@(negedge clock);
		burst_interleave = 1'b1;
		additive_latency = 3'h1;
		cas_latency = 3'h4;
		fork
			begin
				u_ddrci_ctrl_model.cmd(4'h5, 2'h1, 13'h000b, 0, 0, 16'h0, 2'h0);
				u_ddrci_ctrl_model.run(9);
			end
			begin
				wait_hi(0);
				t0 = $time;
				`CHK(cmd_r.kind, ddrci_pkg::DDRCI_RD)
				for (i = 0; i < 8; i++) begin
					wait_hi(1);
					t0 = i == 0 ? ($time - t0) / 10 : t0;
					if (i == 0) `CHK(t0 >= 61 && t0 <= 64, 1'b1)
					`CHK(beat_r.col, 10'h008 | 10'(3 ^ i))
					`CHK(beat_r.rise, 1'(i % 2 == 0))
					`CHK(beat_r.wr, 1'b0)
				end
			end
		join
		$display("read done");
	endtask : t_read
	task automatic t_power();
		int n;
		fork
			u_ddrci_ctrl_model.cmd(4'h2, 2'h0, 13'h0400, 0, 0, 16'h0, 2'h0);
			wait_hi(0);
		join
		`CHK(banks_open_r, 4'h0)
		u_ddrci_ctrl_model.set_cke(1'b0);
		u_ddrci_ctrl_model.run(2);
		`CHK(low_power_r, 1'b1)
		n = n_cmd;
		u_ddrci_ctrl_model.cmd(4'h3, 2'h0, 13'h0007, 0, 0, 16'h0, 2'h0);
		u_ddrci_ctrl_model.run(1);
		`CHK(n_cmd, n)
		`CHK(banks_open_r, 4'h0)
		u_ddrci_ctrl_model.set_cke(1'b1);
		u_ddrci_ctrl_model.run(2);
		`CHK(low_power_r, 1'b0)
		// A frozen block must miss an activate entirely
		@(negedge clock);
		clk_en = 1'b0;
		u_ddrci_ctrl_model.cmd(4'h3, 2'h3, 13'h0001, 0, 0, 16'h0, 2'h0);
		`CHK(banks_open_r, 4'h0)
		@(negedge clock);
		clk_en = 1'b1;
		u_ddrci_ctrl_model.run(1);
		`CHK(banks_open_r, 4'h0)
		u_ddrci_ctrl_model.set_cke(1'b0);
		u_ddrci_ctrl_model.cmd(4'h1, 2'h0, 13'h0000, 0, 0, 16'h0, 2'h0);
		u_ddrci_ctrl_model.run(1);
		`CHK(self_refresh_r, 1'b1)
		u_ddrci_ctrl_model.set_cke(1'b1);
		u_ddrci_ctrl_model.run(2);
		`CHK(self_refresh_r, 1'b0)
		$display("power done");
	endtask : t_power
	initial begin
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		t_rows();
		t_write();
		t_read();
		t_power();
		tally_and_finish();
	end
endmodule : tb_top
